// ### src/shp_pkg.sv
package shp_pkg;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RESULT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ = 8'h0C;
  localparam logic [7:0] REG_MASK = 8'h10;

  // Control field positions.
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_EXTEND = 1;
  localparam int CTRL_LIMIT = 2;
  localparam int CTRL_FALLEDGE = 3;
  localparam int CTRL_EXTTRIG = 4;
  localparam int CTRL_INIT = 5;
  localparam int CTRL_ACQ = 6;
  localparam int CTRL_DONE = 7;
  localparam int CTRL_W = 8;

  // Result field positions.
  localparam int RES_BIN = 0;
  localparam int RES_PASS = 4;
  localparam int RES_SFAIL = 5;
  localparam int RES_SHIGH = 6;
  localparam int RES_FAULT = 7;
  localparam int RES_OVER = 8;
  localparam int RES_UNDER = 9;
  localparam int RES_NC = 10;
  localparam int RES_W = 11;

  // Interrupt bit positions.
  localparam int IRQ_START = 0;
  localparam int IRQ_ACQ = 1;
  localparam int IRQ_DONE = 2;
  localparam int IRQ_RECALL = 3;
  localparam int IRQ_W = 4;

  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [RES_W-1:0] RES_RESET = 11'h000;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
  localparam int NUM_BINS = 14;
  localparam int NUM_BINS_BASE = 9;
  localparam int MEMSEL_W = 5;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACQ,
    ST_CALC
  } shp_state_t;

endpackage

// ### src/shp_sorter_handler_port.sv
// Operation
// - Slash-named handler lines are active low.
// - Contact fail, over, under only unextended.
// - Limit mode drives fault, secondary, reject lines.
// - Pull acquire done low after acquisition.
// - Measure done low when results valid.
// - Measure fault flags any measurement error.
// - Secondary fail when secondary outside limits.
// - Lockout low ignores every panel key.
// - Fault clears bins, reject, secondary, over, under.
// - Limit mode fault reports primary high, secondary high.
// - Disabled handler holds comparison outputs high.
// - Disabled handler holds both done strobes low.
// - Disabled pattern after reset and initialize.
// - Inputs stay active regardless of comparator.
// - Start on selected edge, rising default.
// - Valid select with external trigger recalls memory.
// - Extension gives fourteen bins, else nine.
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
module shp_sorter_handler_port
  import shp_pkg::*;
(
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Wishbone slave.
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  output logic irq,
  // Handler inputs.
  input wire logic startPulse,
  input wire logic panelLockout_n,
  input wire logic [MEMSEL_W-1:0] memorySelect_n,
  input wire logic memorySelectValid_n,
  // Panel keys and recall request.
  input wire logic panelKeyIn,
  output logic panelKeyOut,
  output logic recallStb,
  output logic [MEMSEL_W-1:0] recallNum,
  // Handler outputs, all active low.
  output logic [NUM_BINS-1:0] sortBin_n,
  output logic rejectAll_n,
  output logic secondaryFail_n,
  output logic measureFault_n,
  output logic contactFailFlag_n,
  output logic primaryOver_n,
  output logic primaryUnder_n,
  output logic acquireDone_n,
  output logic measureDone_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [8:0] syncA_ff, syncB_ff, nxt_syncA, nxt_syncB;
  logic startPrev_ff, nxt_startPrev;

  always_comb begin
    nxt_syncA = {panelKeyIn, startPulse, panelLockout_n, memorySelectValid_n, memorySelect_n};
    nxt_syncB = syncA_ff;
    nxt_startPrev = syncB_ff[7];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // Start and key idle low, the rest idle high, so release shows no false edge.
      syncA_ff <= 9'h07F;
      syncB_ff <= 9'h07F;
      startPrev_ff <= 1'b0;
    end else if (clkEn) begin
      syncA_ff <= nxt_syncA;
      syncB_ff <= nxt_syncB;
      startPrev_ff <= nxt_startPrev;
    end
  end

  logic startS, lockS_n, validS_n, keyS;
  logic [MEMSEL_W-1:0] selS_n;
  assign selS_n = syncB_ff[MEMSEL_W-1:0];
  assign validS_n = syncB_ff[5];
  assign lockS_n = syncB_ff[6];
  assign startS = syncB_ff[7];
  assign keyS = syncB_ff[8];

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus slave.

  logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [RES_W-1:0] res_ff, nxt_res;
  logic [IRQ_W-1:0] irqSt_ff, nxt_irqSt, mask_ff, nxt_mask, events;
  logic [31:0] datO_ff, nxt_datO;
  logic ack_ff, nxt_ack;

  wire logic wrAcc = wbCyc && wbStb && wbWe && !ack_ff && wbSel[0];
  wire logic rdAcc = wbCyc && wbStb && !ack_ff;
  wire logic enable = ctrl_ff[CTRL_ENABLE];

  // Start edge detection on the selected polarity; rising is the reset default.
  wire logic startEdge = ctrl_ff[CTRL_FALLEDGE] ? (startPrev_ff && !startS)
                                                 : (!startPrev_ff && startS);

  function automatic logic [31:0] pad(input logic [15:0] v);
    pad = {16'h0000, v};
  endfunction

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_res = res_ff;
    nxt_mask = mask_ff;
    nxt_ack = rdAcc;
    nxt_datO = 32'h0000_0000;
    // The init bit self-clears so that a single write acts like a menu initialize.
    nxt_ctrl[CTRL_INIT] = 1'b0;
    if (wrAcc && wbAdr == REG_CTRL) begin
      nxt_ctrl = wbDatI[CTRL_W-1:0];
    end
    if (wrAcc && wbAdr == REG_RESULT) begin
      nxt_res = wbDatI[RES_W-1:0];
    end
    if (wrAcc && wbAdr == REG_MASK) begin
      nxt_mask = wbDatI[IRQ_W-1:0];
    end
    if (ctrl_ff[CTRL_INIT]) begin
      nxt_ctrl = CTRL_RESET;
    end
    // Set wins over a simultaneous write-one clear.
    nxt_irqSt = irqSt_ff;
    if (wrAcc && wbAdr == REG_IRQ) begin
      nxt_irqSt = irqSt_ff & ~wbDatI[IRQ_W-1:0];
    end
    nxt_irqSt = nxt_irqSt | events;
    if (rdAcc && !wbWe) begin
      case (wbAdr)
        REG_CTRL: nxt_datO = pad({8'h00, ctrl_ff});
        REG_RESULT: nxt_datO = pad({5'h00, res_ff});
        REG_STATUS: nxt_datO = pad({4'h0, selS_n, !validS_n, !lockS_n, startS, 4'h0});
        REG_IRQ: nxt_datO = pad({12'h000, irqSt_ff});
        REG_MASK: nxt_datO = pad({12'h000, mask_ff});
        default: nxt_datO = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement sequencer.

  shp_state_t state_ff, nxt_state;
  logic acq_ff, nxt_acq, done_ff, nxt_done, rcl_ff, nxt_rcl;
  logic [MEMSEL_W-1:0] rclNum_ff, nxt_rclNum;

  always_comb begin
    nxt_state = state_ff;
    nxt_acq = acq_ff;
    nxt_done = done_ff;
    nxt_rcl = 1'b0;
    nxt_rclNum = rclNum_ff;
    events = IRQ_RESET;
    case (state_ff)
      ST_IDLE: begin
        if (startEdge && enable) begin
          nxt_acq = 1'b0;
          nxt_done = 1'b0;
          nxt_state = ST_ACQ;
          events[IRQ_START] = 1'b1;
        end
      end
      ST_ACQ: begin
        if (wrAcc && wbAdr == REG_CTRL && wbDatI[CTRL_ACQ]) begin
          nxt_acq = 1'b1;
          nxt_state = ST_CALC;
          events[IRQ_ACQ] = 1'b1;
        end
      end
      ST_CALC: begin
        if (wrAcc && wbAdr == REG_CTRL && wbDatI[CTRL_DONE]) begin
          nxt_done = 1'b1;
          nxt_state = ST_IDLE;
          events[IRQ_DONE] = 1'b1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    // Recall is taken on the start edge even if the comparator is off.
    if (startEdge && !validS_n && ctrl_ff[CTRL_EXTTRIG]) begin
      nxt_rcl = 1'b1;
      nxt_rclNum = ~selS_n;
      events[IRQ_RECALL] = 1'b1;
    end
    if (!enable) begin
      nxt_state = ST_IDLE;
      nxt_acq = 1'b1;
      nxt_done = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pin encoding. Results are only shown while measure done is held,
  // so the handler never samples a half-updated pattern.

  logic [NUM_BINS-1:0] nxt_bin;
  logic nxt_rej, nxt_sf, nxt_mf, nxt_nc, nxt_ov, nxt_un, nxt_key;
  logic [3:0] binIdx;
  logic fault, limitMode, extend, valid;

  always_comb begin
    binIdx = res_ff[RES_BIN+3:RES_BIN];
    fault = res_ff[RES_FAULT];
    limitMode = ctrl_ff[CTRL_LIMIT];
    extend = ctrl_ff[CTRL_EXTEND];
    valid = enable && done_ff && state_ff == ST_IDLE;
    nxt_bin = {NUM_BINS{1'b0}};
    nxt_rej = 1'b0;
    nxt_sf = 1'b0;
    nxt_mf = 1'b0;
    nxt_nc = 1'b0;
    nxt_ov = 1'b0;
    nxt_un = 1'b0;
    if (valid) begin
      nxt_mf = fault;
      nxt_nc = res_ff[RES_NC] && !extend;
      if (limitMode) begin
        // Limit mode reuses bin pins: 0 primary high, 1 primary in, 2 primary low.
        // Then 3 secondary high, 4 secondary in, 5 secondary low, 6 total pass.
        if (fault) begin
          nxt_bin[0] = 1'b1;
          nxt_bin[3] = 1'b1;
        end else begin
          nxt_bin[binIdx[1:0] == 2'h0 ? 0 : (binIdx[1:0] == 2'h1 ? 1 : 2)] = 1'b1;
          nxt_bin[3] = res_ff[RES_SFAIL] && res_ff[RES_SHIGH];
          nxt_bin[4] = !res_ff[RES_SFAIL];
          nxt_bin[5] = res_ff[RES_SFAIL] && !res_ff[RES_SHIGH];
          nxt_bin[6] = res_ff[RES_PASS];
          nxt_rej = !res_ff[RES_PASS];
          nxt_sf = res_ff[RES_SFAIL];
        end
      end else if (!fault) begin
        // Bins above nine are dropped unless extension is on.
        if (binIdx != 4'h0 && binIdx <= (extend ? 4'(NUM_BINS) : 4'(NUM_BINS_BASE))) begin
          nxt_bin[binIdx - 4'h1] = 1'b1;
        end else begin
          nxt_rej = 1'b1;
        end
        nxt_sf = res_ff[RES_SFAIL];
        nxt_ov = res_ff[RES_OVER] && !extend;
        nxt_un = res_ff[RES_UNDER] && !extend;
      end
    end
    nxt_key = keyS && lockS_n;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RESET;
      res_ff <= RES_RESET;
      irqSt_ff <= IRQ_RESET;
      mask_ff <= IRQ_RESET;
      datO_ff <= 32'h0000_0000;
      ack_ff <= 1'b0;
      state_ff <= ST_IDLE;
      acq_ff <= 1'b1;
      done_ff <= 1'b1;
      rcl_ff <= 1'b0;
      rclNum_ff <= 5'h00;
      sortBin_n <= {NUM_BINS{1'b1}};
      rejectAll_n <= 1'b1;
      secondaryFail_n <= 1'b1;
      measureFault_n <= 1'b1;
      contactFailFlag_n <= 1'b1;
      primaryOver_n <= 1'b1;
      primaryUnder_n <= 1'b1;
      acquireDone_n <= 1'b0;
      measureDone_n <= 1'b0;
      panelKeyOut <= 1'b0;
      irq <= 1'b0;
    end else if (clkEn) begin
      ctrl_ff <= nxt_ctrl;
      res_ff <= nxt_res;
      irqSt_ff <= nxt_irqSt;
      mask_ff <= nxt_mask;
      datO_ff <= nxt_datO;
      ack_ff <= nxt_ack;
      state_ff <= nxt_state;
      acq_ff <= nxt_acq;
      done_ff <= nxt_done;
      rcl_ff <= nxt_rcl;
      rclNum_ff <= nxt_rclNum;
      sortBin_n <= ~nxt_bin;
      rejectAll_n <= ~nxt_rej;
      secondaryFail_n <= ~nxt_sf;
      measureFault_n <= ~nxt_mf;
      contactFailFlag_n <= ~nxt_nc;
      primaryOver_n <= ~nxt_ov;
      primaryUnder_n <= ~nxt_un;
      // Strobes follow the state flops so done falls on the edge the results appear.
      acquireDone_n <= ~acq_ff;
      measureDone_n <= ~done_ff;
      panelKeyOut <= nxt_key;
      irq <= |(nxt_irqSt & nxt_mask);
    end
  end

  assign wbDatO = datO_ff;
  assign wbAck = ack_ff;
  assign recallStb = rcl_ff;
  assign recallNum = rclNum_ff;

endmodule

// ### dv/shp_sorter_handler_port_props.sv
`timescale 1ns/1ns
module shp_handler_props
  import shp_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Bus and pins.
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  input wire logic wbAck,
  input wire logic panelLockout_n,
  input wire logic panelKeyOut,
  input wire logic recallStb,
  input wire logic [NUM_BINS-1:0] sortBin_n,
  input wire logic rejectAll_n,
  input wire logic secondaryFail_n,
  input wire logic measureFault_n,
  input wire logic contactFailFlag_n,
  input wire logic primaryOver_n,
  input wire logic primaryUnder_n,
  input wire logic acquireDone_n,
  input wire logic measureDone_n
);
  // The pins lag a control write by one edge, so they follow the delayed copy of the mode.
  logic [7:0] ctl_ff;
  logic [7:0] mode_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_ff <= 8'h00;
      mode_ff <= 8'h00;
    end else begin
      if (wbCyc && wbStb && wbWe && wbSel[0] && !wbAck && wbAdr == REG_CTRL)
        ctl_ff <= wbDatI[7:0];
      else if (ctl_ff[5])
        ctl_ff <= 8'h00;
      mode_ff <= ctl_ff;
    end
  end
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  property p_disOut;
    !ctl_ff[0] [*3] |-> &sortBin_n && rejectAll_n && secondaryFail_n && measureFault_n;
  endproperty
  a_disOut: assert property (p_disOut) else $error("result active while off");
  property p_disDone;
    !ctl_ff[0] [*3] |-> !acquireDone_n && !measureDone_n;
  endproperty
  a_disDone: assert property (p_disDone) else $error("strobes high while off");
  property p_fault;
    !measureFault_n |-> rejectAll_n && secondaryFail_n && primaryOver_n && primaryUnder_n
      && (mode_ff[2] || &sortBin_n);
  endproperty
  a_fault: assert property (p_fault) else $error("sort lines during fault");
  property p_ext;
    mode_ff[0] && mode_ff[1] && !measureDone_n
      |-> contactFailFlag_n && primaryOver_n && primaryUnder_n;
  endproperty
  a_ext: assert property (p_ext) else $error("over or under with extension");
  property p_lim;
    mode_ff[0] && mode_ff[2] && !measureDone_n && measureFault_n |-> rejectAll_n != sortBin_n[6];
  endproperty
  a_lim: assert property (p_lim) else $error("reject not inverse of pass");
  property p_limFault;
    mode_ff[0] && mode_ff[2] && !measureFault_n |-> !sortBin_n[0] && !sortBin_n[3];
  endproperty
  a_limFault: assert property (p_limFault) else $error("limit fault pattern");
  property p_order;
    $fell(measureDone_n) |-> !acquireDone_n;
  endproperty
  a_order: assert property (p_order) else $error("done before acquire");
  property p_lock;
    !panelLockout_n [*5] |-> !panelKeyOut;
  endproperty
  a_lock: assert property (p_lock) else $error("key passed while locked");
  c_lim: cover property (mode_ff[2] && !measureDone_n);
  c_flt: cover property (!measureFault_n);
  c_rcl: cover property (recallStb);
endmodule
bind shp_sorter_handler_port shp_handler_props shp_handler_props_i (.*);

// ### dv/shp_handler_model.sv
`timescale 1ns/1ns
module shp_handler_model
  import shp_pkg::*;
(
  // Clock and results.
  input wire logic mclk,
  input wire logic [19:0] res_n,
  input wire logic measureDone_n,
  // Start and memory select.
  output logic startPulse,
  output logic [MEMSEL_W-1:0] memorySelect_n,
  output logic memorySelectValid_n
);
  logic [19:0] seen;
  initial begin
    startPulse = 1'b0;
    memorySelect_n = 5'h1F;
    memorySelectValid_n = 1'b1;
  end
  // Sorting lines are only read while the end strobe is low.
  always @(posedge mclk) if (!measureDone_n) seen <= res_n;
  // Park at idle first so only the chosen edge starts; select stands over it.
  task automatic start(input logic fall, input logic v, input logic [4:0] n);
    startPulse <= fall;
    memorySelect_n <= ~n;
    memorySelectValid_n <= !v;
    repeat (4) @(posedge mclk);
    startPulse <= !fall;
    repeat (5) @(posedge mclk);
    memorySelectValid_n <= 1'b1;
    memorySelect_n <= n;
  endtask
endmodule

// ### dv/shp_sorter_handler_port_tb.sv
`timescale 1ns/1ns
module shp_sorter_handler_port_tb
  import shp_pkg::*;
;
  logic mclk = 0, rst_n = 0, clkEn = 1, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck, irq;
  logic panelKeyIn = 0, panelLockout_n = 1, panelKeyOut, recallStb;
  logic [7:0] wbAdr = 0;
  logic [3:0] wbSel = 4'hF;
  logic [31:0] wbDatI = 0, wbDatO, q;
  logic startPulse, memorySelectValid_n;
  logic [4:0] memorySelect_n, recallNum;
  logic [13:0] sortBin_n;
  logic rejectAll_n, secondaryFail_n, measureFault_n, contactFailFlag_n;
  logic primaryOver_n, primaryUnder_n, acquireDone_n, measureDone_n;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  int rclSeen = 0, rclBase = 0;
  wire logic [19:0] outs = {sortBin_n, rejectAll_n, secondaryFail_n, measureFault_n,
    contactFailFlag_n, primaryOver_n, primaryUnder_n};
  wire logic [1:0] dn = {acquireDone_n, measureDone_n};
  shp_sorter_handler_port shp_sorter_handler_port_i (.*);
  shp_handler_model shp_handler_model_i (.mclk(mclk), .res_n(outs),
    .measureDone_n(measureDone_n), .startPulse(startPulse),
    .memorySelect_n(memorySelect_n), .memorySelectValid_n(memorySelectValid_n));
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (recallStb) rclSeen <= rclSeen + 1;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wbCyc <= 1;
    wbStb <= 1;
    wbWe <= w;
    wbAdr <= a;
    wbDatI <= d;
    do @(posedge mclk); while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 0;
    wbStb <= 0;
  endtask
  function automatic logic [19:0] expv(logic [7:0] c, logic [10:0] r);
    logic [13:0] b;
    logic rj, sf, nc, ov, un;
    b = '1;
    {rj, sf, nc, ov, un} = 5'h1F;
    if (r[7]) begin
      nc = !(r[10] && !c[1]);
      if (c[2]) {b[0], b[3]} = 2'b00;
    end else if (c[2]) begin
      b[r[1:0] == 0 ? 0 : r[1:0] == 1 ? 1 : 2] = 0;
      b[!r[5] ? 4 : r[6] ? 3 : 5] = 0;
      b[6] = !r[4];
      rj = r[4];
      sf = !r[5];
    end else begin
      if (r[3:0] > 0 && r[3:0] <= (c[1] ? 14 : 9)) b[r[3:0] - 1] = 0;
      else rj = 0;
      sf = !r[5];
      ov = !(r[8] && !c[1]);
      un = !(r[9] && !c[1]);
    end
    return {b, rj, sf, !r[7], nc, ov, un};
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    logic [7:0] c;
    logic [10:0] r;
    logic [4:0] n;
    logic [3:0] m;
    logic v;
    logic [10:0] corner [4] = '{11'h009, 11'h00A, 11'h00E, 11'h480};
    c = 8'($urandom(32920));
    repeat (4) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    chk(outs, 20'hFFFFF);
    chk(dn, 2'h0);
    panelKeyIn <= 1;
    panelLockout_n <= 0;
    repeat (2) @(posedge mclk);
    wb(0, REG_STATUS, 0);
    chk(q[5], 1'b1);
    chk(panelKeyOut, 1'b0);
    panelLockout_n <= 1;
    repeat (6) @(posedge mclk);
    chk(panelKeyOut, 1'b1);
    wb(0, 8'h20, 32'hFFFF);
    chk(q, 0);
    for (int i = 0; i < 24; i++) begin
      c = 8'h01 | (8'($urandom) & 8'h1E);
      r = i < 4 ? corner[i] : 11'($urandom);
      r &= c[2] ? 11'h4FF : 11'h7AF;
      r[10] &= r[7];
      {n, v, m} = 10'($urandom);
      wb(1, REG_MASK, m);
      wb(1, REG_CTRL, c);
      wb(1, REG_RESULT, r);
      rclBase = rclSeen;
      shp_handler_model_i.start(c[3], v, n);
      chk(dn, 2'h3);
      wb(1, REG_CTRL, c | 8'h40);
      for (int k = 0; k < 20 && acquireDone_n; k++) @(posedge mclk);
      chk(dn, 2'h1);
      wb(1, REG_CTRL, c | 8'h80);
      for (int k = 0; k < 20 && measureDone_n; k++) @(posedge mclk);
      @(posedge mclk);
      chk(shp_handler_model_i.seen, expv(c, r));
      if (c[4] && v) chk(recallNum, n);
      chk(rclSeen - rclBase, c[4] & v);
      wb(0, REG_IRQ, 0);
      chk(q[3:0], {c[4] & v, 3'h7});
      chk(irq, |(m & {c[4] & v, 3'h7}));
      wb(1, REG_IRQ, 32'hF);
      repeat (2) @(posedge mclk);
      chk(irq, 1'b0);
      $display("test %0d done", i);
    end
    wb(1, REG_CTRL, 8'h21);
    repeat (4) @(posedge mclk);
    chk(outs, 20'hFFFFF);
    chk(dn, 2'h0);
    conclude();
  end
endmodule
